// ### dv/host_model.sv
/*
 * host side of the serial link: frame sync, serial clock, data in,
 * and a capture of the chained data out.
 * assumes i_clk is the bench clock; serial clock idles high.
 */
`timescale 1ns/1ps
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_chain,
  input  wire logic        i_sdo,
  output logic             o_sync_n,
  output logic             o_sclk,
  output logic             o_sdi,
  output logic      [15:0] o_rx
);
  localparam int HALF = 10;  // 80 ns half period, 160 ns serial clock
  initial begin
    o_sync_n = 1'b1;
    o_sclk   = 1'b1;
    o_sdi    = 1'b0;
    o_rx     = 16'h0000;
  end
  // send the top n bits of w; a short n makes a truncated frame
  task automatic send(input logic [15:0] w, input int n);
    repeat (HALF) @(posedge i_clk);
    o_sync_n <= 1'b0;  // falling sync opens the word
    for (int i = 15; i > 15 - n; i--) begin
      o_sdi <= w[i];  // msb first, n bits from bit 15 down
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      // chained bit moves a few cycles after the fall, so read it late
      o_rx   <= {o_rx[14:0], i_sdo};
      o_sclk <= 1'b1;
    end
    repeat (HALF) @(posedge i_clk);
    o_sync_n <= 1'b1;
    o_sdi    <= ~o_sdi;  // released line never shows the stale bit
    if (i_chain) begin
      // one extra fall readies the chained port
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
  endtask : send
endmodule : host_model

// ### dv/testbench.sv
/*
 * self-checking bench for the command decoder: host model on the
 * serial pins, wishbone reads and writes, clear and power-down pins.
 * assumes the decoder answers 3 to 4 cycles after sync rises.
 */
`timescale 1ns/1ps
module testbench
  import dac_cmd_pkg::*;
;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  logic              clr_n = 1'b1;
  logic              chain = 1'b0;
  logic              pdp   = 1'b0;
  logic              cyc   = 1'b0;
  logic              stb   = 1'b0;
  logic              we    = 1'b0;
  logic [3:0]        adr   = 4'h0;
  logic [31:0]       wdat  = 32'h0000_0000;
  logic [3:0]        sel   = 4'h0;
  logic              sync_n, sclk, sdi, serial_word_out, ack;
  logic [15:0]       rx;
  logic [11:0]       dac_a, dac_b;
  logic [31:0]       rdat;
  pd_mode_t          pda, pdb;
  logic [11:0]       ia, ib, oa, ob;  // expected register contents
  int                fails    = 0;
  int                compares = 0;

  always #4 clk = ~clk;  // 125 MHz

  host_model i_host_model (.i_clk(clk), .i_chain(chain), .i_sdo(serial_word_out),
    .o_sync_n(sync_n), .o_sclk(sclk), .o_sdi(sdi), .o_rx(rx));

  dac_cmd_decoder i_dac_cmd_decoder (.i_clk(clk), .i_rst_n(rst_n),
    .i_frame_sync_n(sync_n), .i_serial_clk(sclk),
    .i_serial_word_in(sdi), .i_async_clear_n(clr_n),
    .i_chain_enable(chain), .i_power_down_pin(pdp),
    .o_serial_word_out(serial_word_out), .o_dac_a_code(dac_a),
    .o_dac_b_code(dac_b), .o_pd_mode_a(pda), .o_pd_mode_b(pdb),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat));

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // classic single cycle; the wait is bounded by the bench only
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    // a wait that never sees ack is ended by the watchdog
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;  // taken at the edge that saw ack
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk("reg", e, q);
  endtask : rd

  // ports and both code registers against the expected state
  task automatic regs();
    chk("dac_a", {20'h0, oa}, {20'h0, dac_a});
    chk("dac_b", {20'h0, ob}, {20'h0, dac_b});
    rd(REG_CODE_A, {4'h0, ia, 4'h0, oa});
    rd(REG_CODE_B, {4'h0, ib, 4'h0, ob});
  endtask : regs

  task automatic frame(input logic [15:0] w, input int n);
    i_host_model.send(w, n);
    repeat (6) @(posedge clk);  // decode lands 3-4 cycles after rise
  endtask : frame

  // one command: predict its effect, send it, compare code ports and registers
  task automatic cmd(input logic [2:0] c, input logic [11:0] d);
    if (c inside {3'h0, 3'h2, 3'h3, 3'h6}) ia = d;
    if (c inside {3'h1, 3'h4, 3'h5, 3'h6}) ib = d;
    if (c inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7}) oa = ia;
    if (c inside {3'h3, 3'h4, 3'h5, 3'h6, 3'h7}) ob = ib;
    frame({c, 1'b0, d}, 16);
    regs();
  endtask : cmd

  task automatic t_table();
    logic [2:0]  cs[10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
                            3'h5, 3'h6, 3'h0, 3'h1, 3'h7};
    logic [11:0] ds[10] = '{12'h123, 12'h456, 12'h111, 12'h222,
                            12'h333, 12'h444, 12'h555, 12'h666,
                            12'h777, 12'hABC};
    for (int i = 0; i < 10; i++) begin
      cmd(cs[i], ds[i]);
    end
    $display("test table done");
  endtask : t_table

  task automatic t_misc();
    logic [31:0] q;
    wb(1'b1, REG_CTRL, 32'h0000_0000, q);  // decoding switched off
    frame(16'hCFFF, 16);
    regs();
    wb(1'b1, REG_CTRL, 32'h0000_0001, q);
    frame(16'hCFFF, 12);  // short frame is dropped
    regs();
    $display("test misc done");
  endtask : t_misc

  task automatic t_clear();
    clr_n <= 1'b0;
    repeat (4) @(posedge clk);
    {ia, ib, oa, ob} = 48'h0;
    regs();
    frame(16'hC321, 16);  // ignored while clear is low
    regs();
    clr_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmd(3'h2, 12'h0AB);
    $display("test clear done");
  endtask : t_clear

  task automatic t_pd();
    frame(16'h5400, 16);
    chk("pd_a", {30'h0, PD_1K}, {30'h0, pda});
    chk("pd_b", {30'h0, PD_ACTIVE}, {30'h0, pdb});
    frame(16'h1800, 16);
    chk("pd_b", {30'h0, PD_100K}, {30'h0, pdb});
    pdp <= 1'b1;
    repeat (5) @(posedge clk);
    chk("pd_a", {30'h0, PD_HIZ}, {30'h0, pda});
    // 13 decoded frames, 16 bits counted, pins, both channels floating
    rd(REG_STATUS, 32'h000D_1065);
    pdp <= 1'b0;
    cmd(3'h7, 12'h000);  // loading outputs wakes both channels
    chk("pd_a", {30'h0, PD_ACTIVE}, {30'h0, pda});
    $display("test power-down done");
  endtask : t_pd

  task automatic t_chain();
    chk("sdo_off", 32'h0, {31'h0, serial_word_out});
    chain <= 1'b1;
    @(posedge clk);
    i_host_model.send(16'h0A5C, 16);
    i_host_model.send(16'h0F0F, 16);
    chk("chained", 32'h0A5C, {16'h0, rx});
    ia = 12'hF0F;  // both chained words were channel A stores
    regs();
    chain <= 1'b0;
    $display("test chain done");
  endtask : t_chain

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    {ia, ib, oa, ob} = 48'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(REG_CTRL, 32'h0000_0001);
    rd(4'h2, 32'h0000_0000);  // unmapped place reads zero
    regs();
    t_table();
    t_misc();
    t_clear();
    t_pd();
    t_chain();
    results();
  end

  // about 20 frames of 350 cycles; far beyond that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    results();
  end
endmodule : testbench

// ### hw/dac_cmd_decoder.sv
/*
 * serial command front end of a dual 12-bit converter: frame sync,
 * serial clock and data pins are sampled on i_clk, words are decoded
 * into store/update operations on two input and two output registers,
 * with power-down modes, clear pin and a wishbone register window.
 * assumes the serial clock is much slower than i_clk (at least four
 * i_clk periods per half cycle) and a classic wishbone master.
 */
// The implementer's own choices: the placing of the registers and the Wishbone register port.
// Behaviour
// - falling frame sync starts a new word; chain mode restarts at the first clock fall after sync rises
// - clear low zeroes both output registers
// - code 0000 stores channel A input only
// - code 0010 stores channel B input only
// - code 0100 writes A input and output
// - code 0110 writes A, loads B output
// - code 1000 writes B input and output
// - code 1010 writes B, loads A output
// - code 1100 writes both channels' registers
// - code 1110 loads both outputs from inputs
// - sixteen-bit word: control then twelve-bit code
// - bit 12 set means power-down command
// - after clear, update at next sync rise
`timescale 1ns/1ps
module dac_cmd_decoder
  import dac_cmd_pkg::*;
#(
  parameter int ADR_W = WB_ADR_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // serial pins
  input  wire logic              i_frame_sync_n,
  input  wire logic              i_serial_clk,
  input  wire logic              i_serial_word_in,
  input  wire logic              i_async_clear_n,
  input  wire logic              i_chain_enable,
  input  wire logic              i_power_down_pin,
  output logic                   o_serial_word_out,
  // converter side
  output logic      [CODE_W-1:0] o_dac_a_code,
  output logic      [CODE_W-1:0] o_dac_b_code,
  output pd_mode_t               o_pd_mode_a,
  output pd_mode_t               o_pd_mode_b,
  // wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic                   o_wb_ack,
  output logic      [31:0]       o_wb_dat
);
  localparam int CNT_W = $clog2(WORD_W + 1);

  // all state of the block
  typedef struct packed {
    logic              fs_prev;     // last synced frame sync
    logic              sclk_prev;   // last synced serial clock
    logic              init_armed;  // chain mode waits for a clock fall
    logic              ctrl_en;     // software lets frames act
    logic [CODE_W-1:0] in_a;        // channel A input register
    logic [CODE_W-1:0] in_b;        // channel B input register
    logic [CODE_W-1:0] dac_a;       // channel A output register
    logic [CODE_W-1:0] dac_b;       // channel B output register
    pd_mode_t          pd_a;        // commanded state of channel A
    pd_mode_t          pd_b;        // commanded state of channel B
    pd_mode_t          pd_out_a;    // state after the power-down pin
    pd_mode_t          pd_out_b;
    logic [FRM_W-1:0]  frames;      // decoded words, wraps
    logic              ack;         // wishbone acknowledge
    logic [31:0]       rdat;        // wishbone read data
  } state_t;

  state_t r_r;
  state_t r_nxt;

  // synchronised pins
  logic [PIN_W-1:0]  pins_s;
  logic              fs_s;
  logic              sclk_s;
  logic              clr_s;
  logic              chain_s;
  logic              pdpin_s;

  // edges and shifter handshake
  logic              fs_fall;
  logic              fs_rise;
  logic              sclk_fall;
  logic              sh_shift;
  logic              sh_restart;
  logic [WORD_W-1:0] sh_word;
  logic [CNT_W-1:0]  sh_count;
  logic              sh_full;
  logic              sh_sdo;

  // decoded word
  logic              go;
  logic              pd_bit;
  logic [2:0]        cmd;
  logic [1:0]        pd_sel;
  logic [CODE_W-1:0] code;
  logic              bus_req;

  // power-down mode field: both ends of the range float the output
  function automatic pd_mode_t pd_decode(input logic [1:0] f);
    pd_mode_t m;
    unique case (f)
      2'h1:    m = PD_1K;
      2'h2:    m = PD_100K;
      default: m = PD_HIZ;
    endcase
    return m;
  endfunction : pd_decode

  // every pin is foreign to i_clk, so all six pass two flops
  pin_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_power_down_pin, i_chain_enable, i_async_clear_n,
               i_serial_word_in, i_serial_clk, i_frame_sync_n}),
    .o_q     (pins_s)
  );

  assign fs_s    = pins_s[PIN_FS];
  assign sclk_s  = pins_s[PIN_SC];
  assign clr_s   = pins_s[PIN_CL];
  assign chain_s = pins_s[PIN_CH];
  assign pdpin_s = pins_s[PIN_PD];

  // edges seen against the previous synced sample
  assign fs_fall   = r_r.fs_prev & ~fs_s;
  assign fs_rise   = ~r_r.fs_prev & fs_s;
  assign sclk_fall = r_r.sclk_prev & ~sclk_s;

  // bits are taken only inside a frame
  assign sh_shift = sclk_fall & ~fs_s & clr_s;

  // plain mode restarts the count at the frame start; chain mode keeps
  // shifting through the frame and is reset by the first clock fall
  // after sync rises, which the host must supply
  always_comb begin
    if (!clr_s) begin
      sh_restart = 1'b1;
    end else if (chain_s) begin
      sh_restart = r_r.init_armed & sclk_fall & fs_s;
    end else begin
      sh_restart = fs_fall;
    end
  end

  serial_shifter #(
    .W         (WORD_W)
  ) u_shift (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_restart (sh_restart),
    .i_shift   (sh_shift),
    .i_bit     (pins_s[PIN_DI]),
    .i_chain   (chain_s),
    .o_word    (sh_word),
    .o_count   (sh_count),
    .o_full    (sh_full),
    .o_sdo     (sh_sdo)
  );

  // a word acts at sync rise once sixteen bits are in; a short frame
  // is dropped without effect
  assign go     = fs_rise & sh_full & r_r.ctrl_en & clr_s;
  assign cmd    = sh_word[CB15:CMD_LSB];
  assign pd_bit = sh_word[CB12];
  assign pd_sel = sh_word[CB15:PDS_LSB];
  assign code   = sh_word[CODE_W-1:0];

  assign bus_req = i_wb_cyc & i_wb_stb & ~r_r.ack;

  // next state of the whole block
  always_comb begin
    r_nxt           = r_r;
    r_nxt.fs_prev   = fs_s;
    r_nxt.sclk_prev = sclk_s;
    // chain mode arms its restart at each frame end
    if (fs_rise) begin
      r_nxt.init_armed = 1'b1;
    end else if (sclk_fall & fs_s) begin
      r_nxt.init_armed = 1'b0;
    end
    // command decode
    if (go) begin
      r_nxt.frames = r_r.frames + 1'b1;
      if (pd_bit) begin
        // channel select 01 is A, 10 is B, the others both
        if (pd_sel != PDS_B) begin
          r_nxt.pd_a = pd_decode(sh_word[PDM_LSB+1:PDM_LSB]);
        end
        if (pd_sel != PDS_A) begin
          r_nxt.pd_b = pd_decode(sh_word[PDM_LSB+1:PDM_LSB]);
        end
      end else begin
        // an output register load also wakes that channel
        unique case (cmd)
          CMD_STORE_A: begin
            r_nxt.in_a = code;
          end
          CMD_STORE_B: begin
            r_nxt.in_b = code;
          end
          CMD_UPD_A: begin
            r_nxt.in_a  = code;
            r_nxt.dac_a = code;
            r_nxt.pd_a  = PD_ACTIVE;
          end
          CMD_UPD_A_B: begin
            r_nxt.in_a  = code;
            r_nxt.dac_a = code;
            r_nxt.dac_b = r_r.in_b;
            r_nxt.pd_a  = PD_ACTIVE;
            r_nxt.pd_b  = PD_ACTIVE;
          end
          CMD_UPD_B: begin
            r_nxt.in_b  = code;
            r_nxt.dac_b = code;
            r_nxt.pd_b  = PD_ACTIVE;
          end
          CMD_UPD_B_A: begin
            r_nxt.in_b  = code;
            r_nxt.dac_b = code;
            r_nxt.dac_a = r_r.in_a;
            r_nxt.pd_a  = PD_ACTIVE;
            r_nxt.pd_b  = PD_ACTIVE;
          end
          CMD_UPD_ALL: begin
            r_nxt.in_a  = code;
            r_nxt.in_b  = code;
            r_nxt.dac_a = code;
            r_nxt.dac_b = code;
            r_nxt.pd_a  = PD_ACTIVE;
            r_nxt.pd_b  = PD_ACTIVE;
          end
          CMD_LOAD_AB: begin
            r_nxt.dac_a = r_r.in_a;
            r_nxt.dac_b = r_r.in_b;
            r_nxt.pd_a  = PD_ACTIVE;
            r_nxt.pd_b  = PD_ACTIVE;
          end
        endcase
      end
    end
    // clear behaves like power-on: it wins over any decode
    if (!clr_s) begin
      r_nxt.in_a  = CODE_ZERO;
      r_nxt.in_b  = CODE_ZERO;
      r_nxt.dac_a = CODE_ZERO;
      r_nxt.dac_b = CODE_ZERO;
      r_nxt.pd_a  = PD_ACTIVE;
      r_nxt.pd_b  = PD_ACTIVE;
    end
    // the power-down pin floats both outputs, keeping their codes
    r_nxt.pd_out_a = pdpin_s ? PD_HIZ : r_nxt.pd_a;
    r_nxt.pd_out_b = pdpin_s ? PD_HIZ : r_nxt.pd_b;
    // wishbone: one-cycle answer, unmapped reads zero, writes only reach the control register
    r_nxt.ack  = bus_req;
    r_nxt.rdat = '0;
    if (bus_req) begin
      unique case (i_wb_adr)
        REG_CTRL: begin
          r_nxt.rdat[CTRL_EN_BIT] = r_r.ctrl_en;
          if (i_wb_we & i_wb_sel[0]) begin
            r_nxt.ctrl_en = i_wb_dat[CTRL_EN_BIT];
          end
        end
        REG_CODE_A: begin
          r_nxt.rdat[CODE_OUT_LSB +: CODE_W] = r_r.dac_a;
          r_nxt.rdat[CODE_IN_LSB +: CODE_W]  = r_r.in_a;
        end
        REG_CODE_B: begin
          r_nxt.rdat[CODE_OUT_LSB +: CODE_W] = r_r.dac_b;
          r_nxt.rdat[CODE_IN_LSB +: CODE_W]  = r_r.in_b;
        end
        REG_STATUS: begin
          r_nxt.rdat[ST_PDA_LSB +: 2]     = r_r.pd_out_a;
          r_nxt.rdat[ST_PDB_LSB +: 2]     = r_r.pd_out_b;
          r_nxt.rdat[ST_CHAIN_BIT]        = chain_s;
          r_nxt.rdat[ST_CLR_BIT]          = clr_s;
          r_nxt.rdat[ST_PDPIN_BIT]        = pdpin_s;
          r_nxt.rdat[ST_CNT_LSB +: CNT_W] = sh_count;
          r_nxt.rdat[ST_FRM_LSB +: FRM_W] = r_r.frames;
        end
        default: begin
          r_nxt.rdat = '0;
        end
      endcase
    end
  end

  // register the state; sync idles high so no edge is seen at release
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_r         <= '0;
      r_r.fs_prev <= 1'b1;
      r_r.ctrl_en <= CTRL_EN_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flops
  assign o_dac_a_code      = r_r.dac_a;
  assign o_dac_b_code      = r_r.dac_b;
  assign o_pd_mode_a       = r_r.pd_out_a;
  assign o_pd_mode_b       = r_r.pd_out_b;
  assign o_serial_word_out = sh_sdo;
  assign o_wb_ack          = r_r.ack;
  assign o_wb_dat          = r_r.rdat;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  frame_start_a: assert property (
    fs_fall && !chain_s && !sh_shift |=> sh_count == '0)
    else $error("frame start did not reset the bit count");
  clear_zero_a: assert property (
    !clr_s |=> r_r.dac_a == CODE_ZERO && r_r.dac_b == CODE_ZERO)
    else $error("clear did not zero the output registers");
  store_a_a: assert property (
    go && !pd_bit && cmd == CMD_STORE_A
    |=> r_r.in_a == $past(code) && $stable(r_r.dac_a) && $stable(r_r.dac_b))
    else $error("store A wrong");
  store_b_a: assert property (
    go && !pd_bit && cmd == CMD_STORE_B
    |=> r_r.in_b == $past(code) && $stable(r_r.dac_a) && $stable(r_r.dac_b))
    else $error("store B wrong");
  update_a_a: assert property (
    go && !pd_bit && cmd == CMD_UPD_A
    |=> r_r.dac_a == $past(code) && r_r.in_a == $past(code))
    else $error("update A wrong");
  update_a_load_b_a: assert property (
    go && !pd_bit && cmd == CMD_UPD_A_B
    |=> r_r.dac_a == $past(code) && r_r.dac_b == $past(r_r.in_b))
    else $error("update A with load B wrong");
  update_b_a: assert property (
    go && !pd_bit && cmd == CMD_UPD_B
    |=> r_r.dac_b == $past(code) && r_r.in_b == $past(code))
    else $error("update B wrong");
  update_b_load_a_a: assert property (
    go && !pd_bit && cmd == CMD_UPD_B_A
    |=> r_r.dac_b == $past(code) && r_r.dac_a == $past(r_r.in_a))
    else $error("update B with load A wrong");
  update_all_a: assert property (
    go && !pd_bit && cmd == CMD_UPD_ALL
    |=> r_r.dac_a == $past(code) && r_r.dac_b == $past(code))
    else $error("update all wrong");
  load_all_a: assert property (
    go && !pd_bit && cmd == CMD_LOAD_AB
    |=> r_r.dac_a == $past(r_r.in_a) && r_r.dac_b == $past(r_r.in_b))
    else $error("load all wrong");
  power_down_a: assert property (
    go && pd_bit && pd_sel == PDS_A
    |=> r_r.pd_a == pd_decode($past(sh_word[PDM_LSB+1:PDM_LSB]))
        && $stable(r_r.pd_b))
    else $error("power-down of channel A wrong");
  msb_first_a: assert property (
    sh_shift |=> sh_word == {$past(sh_word[WORD_W-2:0]), $past(pins_s[PIN_DI])})
    else $error("serial bit not shifted in at bit 0");
  chain_out_a: assert property (
    sh_shift && chain_s |=> o_serial_word_out == $past(sh_word[WORD_W-1]))
    else $error("chained output bit wrong");
endmodule : dac_cmd_decoder

// ### hw/dac_cmd_pkg.sv
/*
 * constants shared by the serial command decoder of a dual 12-bit
 * converter: word layout, command codes, power-down modes and the
 * wishbone register map. assumes nothing of its surroundings.
 */
package dac_cmd_pkg;
  // serial word layout
  localparam int WORD_W    = 16;   // bits per command word
  localparam int CODE_W    = 12;   // converter code width
  localparam int CB15      = 15;   // top control bit
  localparam int CB12      = 12;   // power-down flag bit
  localparam int CMD_LSB   = 13;   // command field is bits 15..13
  localparam int PDM_LSB   = 10;   // power-down mode field 11..10
  localparam int PDS_LSB   = 14;   // power-down channel select 15..14
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  // command field (bits 15..13) when the power-down flag is zero
  localparam logic [2:0] CMD_STORE_A = 3'h0;
  localparam logic [2:0] CMD_STORE_B = 3'h1;
  localparam logic [2:0] CMD_UPD_A   = 3'h2;
  localparam logic [2:0] CMD_UPD_A_B = 3'h3;
  localparam logic [2:0] CMD_UPD_B   = 3'h4;
  localparam logic [2:0] CMD_UPD_B_A = 3'h5;
  localparam logic [2:0] CMD_UPD_ALL = 3'h6;
  localparam logic [2:0] CMD_LOAD_AB = 3'h7;
  // power-down channel select codes
  localparam logic [1:0] PDS_A = 2'h1;
  localparam logic [1:0] PDS_B = 2'h2;
  // output state of one channel
  typedef enum logic [1:0] {PD_ACTIVE, PD_HIZ, PD_1K, PD_100K} pd_mode_t;
  // pin bundle order inside the synchroniser
  localparam int PIN_W  = 6;
  localparam int PIN_FS = 0;
  localparam int PIN_SC = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_CL = 3;
  localparam int PIN_CH = 4;
  localparam int PIN_PD = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h09;  // frame and clear idle high
  // wishbone register map (byte addresses)
  localparam int WB_ADR_W = 4;
  localparam logic [WB_ADR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [WB_ADR_W-1:0] REG_CODE_A = 4'h4;
  localparam logic [WB_ADR_W-1:0] REG_CODE_B = 4'h8;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'hC;
  localparam int   CTRL_EN_BIT  = 0;
  localparam logic CTRL_EN_RST  = 1'b1;
  localparam int   CODE_OUT_LSB = 0;
  localparam int   CODE_IN_LSB  = 16;
  localparam int   ST_PDA_LSB   = 0;
  localparam int   ST_PDB_LSB   = 2;
  localparam int   ST_CHAIN_BIT = 4;
  localparam int   ST_CLR_BIT   = 5;
  localparam int   ST_PDPIN_BIT = 6;
  localparam int   ST_CNT_LSB   = 8;
  localparam int   ST_FRM_LSB   = 16;
  localparam int   FRM_W        = 8;
endpackage : dac_cmd_pkg

// ### hw/pin_sync.sv
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes the inputs are asynchronous levels; the first stage is read
 * only by the second.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;  // metastable stage
    logic [W-1:0] s2;  // settled stage
  } sync_t;

  sync_t r_r;
  sync_t r_nxt;

  // next state: plain two-deep shift
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = i_d;
    r_nxt.s2 = r_r.s1;
  end

  // register with idle levels at reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_r <= {RST_VAL, RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_q = r_r.s2;
endmodule : pin_sync

// ### hw/serial_shifter.sv
/*
 * input shift register of the serial port, msb first, with a saturating
 * bit count and the chained serial output.
 * assumes shift and restart are one-cycle pulses on i_clk.
 */
`timescale 1ns/1ps
module serial_shifter #(
  parameter int W     = 16,
  parameter int CNT_W = $clog2(W + 1)
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_restart,  // zero the count
  input  wire logic             i_shift,    // take one bit
  input  wire logic             i_bit,
  input  wire logic             i_chain,
  output logic      [W-1:0]     o_word,
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_full,
  output logic                  o_sdo
);
  typedef struct packed {
    logic [W-1:0]     shreg;  // captured bits, newest at bit 0
    logic [CNT_W-1:0] count;  // bits since restart, saturates at W
    logic             serial_word_out;    // bit pushed out of the top
  } shift_t;

  shift_t r_r;
  shift_t r_nxt;

  // a restart and a shift in one cycle count the new bit as the first
  always_comb begin
    r_nxt = r_r;
    if (i_restart) begin
      r_nxt.count = '0;
    end
    if (i_shift) begin
      r_nxt.shreg = {r_r.shreg[W-2:0], i_bit};
      if (i_restart) begin
        r_nxt.count = CNT_W'(1);
      end else if (r_r.count != CNT_W'(W)) begin
        r_nxt.count = r_r.count + 1'b1;
      end
      r_nxt.serial_word_out = i_chain & r_r.shreg[W-1];
    end
    if (!i_chain) begin
      r_nxt.serial_word_out = 1'b0;  // output idles low outside chain mode
    end
  end

  // register the state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_word  = r_r.shreg;
  assign o_count = r_r.count;
  assign o_full  = (r_r.count == CNT_W'(W));
  assign o_sdo   = r_r.serial_word_out;
endmodule : serial_shifter
